//--- cpt_pkg.sv
// Purpose: constants and state type of the compare/pwm timer
// Assumes: byte-wide registers, each in one aligned 32-bit word
// Notes: offsets are word-aligned byte addresses on the lite bus
package cpt_pkg;
  // register byte addresses
  localparam logic [7:0] CPT_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] CPT_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] CPT_OFF_CNT_LO = 8'h08;
  localparam logic [7:0] CPT_OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] CPT_OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] CPT_OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] CPT_OFF_PERIOD = 8'h18;
  localparam logic [7:0] CPT_OFF_STATUS = 8'h1C;
  // control 0 field
  localparam int CPT_RUN_BIT = 3;
  // control 1 fields
  localparam int CPT_MODE_HI = 7;
  localparam int CPT_MODE_LO = 6;
  localparam int CPT_ACT_HI = 5;
  localparam int CPT_ACT_LO = 4;
  localparam int CPT_INIT_BIT = 2 + 1;
  localparam int CPT_INV_BIT = 2;
  localparam int CPT_SWAP_BIT = 1;
  localparam int CPT_CLR_BIT = 0;
  // status fields, write one to clear
  localparam int CPT_FLAG_A_BIT = 0;
  localparam int CPT_FLAG_P_BIT = 1;
  // operating modes
  localparam logic [1:0] CPT_MODE_COMPARE = 2'h0;
  localparam logic [1:0] CPT_MODE_PWM = 2'h2;
  localparam logic [1:0] CPT_MODE_TIMER = 2'h3;
  // pin actions, compare mode
  localparam logic [1:0] CPT_ACT_NONE = 2'h0;
  localparam logic [1:0] CPT_ACT_LOW = 2'h1;
  localparam logic [1:0] CPT_ACT_HIGH = 2'h2;
  localparam logic [1:0] CPT_ACT_TOGGLE = 2'h3;
  // pin actions, pwm mode
  localparam logic [1:0] CPT_PWM_INACTIVE = 2'h0;
  localparam logic [1:0] CPT_PWM_ACTIVE = 2'h1;
  localparam logic [1:0] CPT_PWM_WAVE = 2'h2;
  // bus responses
  localparam logic [1:0] CPT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPT_RESP_SLVERR = 2'h2;
  // counting constants
  localparam logic [16:0] CPT_FULL_SPAN = 17'h10000;
  localparam logic [7:0] CPT_LOW_ZERO = 8'h00;

  // whole state of the timer
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic have_aw;
    logic have_w;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic run;
    logic run_prev;
    logic [7:0] ctrl1;
    logic [15:0] cmpa;
    logic [7:0] period;
    logic [15:0] count;
    logic [15:0] div;
    logic flag_a;
    logic flag_p;
    logic pin_level;
    logic pin;
    logic pin_en_n;
  } cpt_state_type;

  // pin released, everything else cleared
  localparam cpt_state_type CPT_RESET_STATE = '{pin_en_n: 1'b1, default: '0};
endpackage : cpt_pkg

//--- cpt_timer.sv
// Purpose: 16-bit timer with full compare A and upper-byte compare P, pwm output
// Assumes: one clock aclk, synchronous active-low reset, lite bus master
// Notes: the timer tick is aclk divided by tick_div
//
// Notes on behaviour
// - counter readable as two read-only bytes
// - compare A sixteen bits, two writable bytes
// - period value compared with counter top byte
// - period N times 256, zero gives 65536
// - two mode bits select operating mode
// - clear select low: clear on P, both flags
// - clear select high: clear on A, A flag
// - compare A zero: overflow, no A flag
// - compare pin moves only on A match
// - pin action drives high, low, toggles
// - run rise loads pin initial level
// - timer mode counts alike, pin released
// - pwm ignores clear select, swap picks roles
// - swap low: period from P, duty A
// - swap high: period A, duty from P
// - duty at or above period: always active
// - pwm raises both flags on matches
// - pwm polarity, pin action, invert bit
// - pwm counting continues while pin forced
// - compare codes: none, low, high, toggle
// - run rise zeroes counter, fall holds it
// - pwm codes: inactive, active, wave; pulse code drives inactive
`timescale 1ns/1ps
module cpt_timer
  import cpt_pkg::*;
#(
  parameter logic [15:0] tick_div = 16'h0001 // aclk cycles per timer tick
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_output_pin,
  output logic timer_output_pin_en_n
);

  cpt_state_type q; // registered state
  cpt_state_type d; // next state

  // mapped-address check, shared by read and write
  function automatic logic cpt_mapped(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    if (a == CPT_OFF_CTRL0) begin
      cpt_mapped = 1'b1;
    end else if (a == CPT_OFF_CTRL1 || a == CPT_OFF_CNT_LO || a == CPT_OFF_CNT_HI) begin
      cpt_mapped = 1'b1;
    end else if (a == CPT_OFF_CMPA_LO || a == CPT_OFF_CMPA_HI) begin
      cpt_mapped = 1'b1;
    end else if (a == CPT_OFF_PERIOD || a == CPT_OFF_STATUS) begin
      cpt_mapped = 1'b1;
    end else begin
      cpt_mapped = 1'b0;
    end
  endfunction : cpt_mapped

  // field views of control 1
  logic [1:0] mode; // operating mode
  logic [1:0] action; // pin action code
  logic init_level; // compare initial level, pwm active level
  logic invert; // output inversion
  logic swap; // duty and period swap
  logic clear_sel; // counter clear select
  assign mode = {q.ctrl1[CPT_MODE_HI], q.ctrl1[CPT_MODE_LO]};
  assign action = {q.ctrl1[CPT_ACT_HI], q.ctrl1[CPT_ACT_LO]};
  assign init_level = q.ctrl1[CPT_INIT_BIT];
  assign invert = q.ctrl1[CPT_INV_BIT];
  assign swap = q.ctrl1[CPT_SWAP_BIT];
  assign clear_sel = q.ctrl1[CPT_CLR_BIT];

  // comparator terms, matched against the value the counter would step to
  logic rise; // run enable rising
  logic tick; // one timer clock
  logic [16:0] next_count; // counter plus one, carry kept
  logic [16:0] target_p; // comparator P point, 65536 when zero
  logic [16:0] target_a; // comparator A point, 65536 when zero
  logic a_hit; // comparator A match
  logic p_hit; // comparator P match
  logic pwm_mode; // pwm selected
  logic [16:0] pwm_period; // counter wrap point in pwm
  logic [16:0] pwm_duty; // active span in pwm
  logic clr; // counter returns to zero
  logic pwm_on; // pwm waveform in active phase
  assign rise = q.run && !q.run_prev;
  assign tick = (q.div == tick_div - 16'h1);
  assign next_count = {1'b0, q.count} + 17'h1;
  assign target_p = (q.period == CPT_LOW_ZERO) ? CPT_FULL_SPAN : {1'b0, q.period, CPT_LOW_ZERO};
  assign target_a = (q.cmpa == 16'h0) ? CPT_FULL_SPAN : {1'b0, q.cmpa};
  assign a_hit = (q.cmpa != 16'h0) && (next_count == {1'b0, q.cmpa});
  assign p_hit = (next_count == target_p);
  assign pwm_mode = (mode == CPT_MODE_PWM);
  assign pwm_period = swap ? target_a : target_p;
  assign pwm_duty = swap ? target_p : {1'b0, q.cmpa};
  assign pwm_on = ({1'b0, q.count} < pwm_duty);

  // clear point: pwm wraps at its period, other modes follow clear select
  always_comb begin
    if (pwm_mode) begin
      clr = (next_count == pwm_period);
    end else if (clear_sel) begin
      clr = (q.cmpa == 16'h0) ? next_count[16] : a_hit;
    end else begin
      clr = p_hit;
    end
  end

  // next-state logic: bus slave, counter, flags and pin
  always_comb begin
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    logic [7:0] wa;
    logic [7:0] ra;
    logic clr_a;
    logic clr_p;
    logic set_a;
    logic set_p;
    logic pwm_level;
    aw_fire = s_axi_awvalid && q.awready;
    w_fire = s_axi_wvalid && q.wready;
    ar_fire = s_axi_arvalid && q.arready;
    do_write = q.have_aw && q.have_w && !q.bvalid;
    wa = {q.awaddr[7:2], 2'b00};
    ra = {s_axi_araddr[7:2], 2'b00};
    clr_a = 1'b0;
    clr_p = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    pwm_level = 1'b0;
    d = q;
    d.run_prev = q.run;
    // write address and data taken in either order
    if (aw_fire) begin
      d.have_aw = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      d.have_w = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    // register write once both halves are held
    if (do_write) begin
      d.have_aw = 1'b0;
      d.have_w = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = cpt_mapped(q.awaddr) ? CPT_RESP_OKAY : CPT_RESP_SLVERR;
      if (q.wstrb0) begin
        if (wa == CPT_OFF_CTRL0) begin
          d.run = q.wdata[CPT_RUN_BIT];
        end else if (wa == CPT_OFF_CTRL1) begin
          d.ctrl1 = q.wdata;
        end else if (wa == CPT_OFF_CMPA_LO) begin
          d.cmpa[7:0] = q.wdata;
        end else if (wa == CPT_OFF_CMPA_HI) begin
          d.cmpa[15:8] = q.wdata;
        end else if (wa == CPT_OFF_PERIOD) begin
          d.period = q.wdata;
        end else if (wa == CPT_OFF_STATUS) begin
          clr_a = q.wdata[CPT_FLAG_A_BIT];
          clr_p = q.wdata[CPT_FLAG_P_BIT];
        end
      end
    end
    // write response held until taken
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read: data latched at the address handshake
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rresp = cpt_mapped(s_axi_araddr) ? CPT_RESP_OKAY : CPT_RESP_SLVERR;
      d.rdata = 32'h0;
      if (ra == CPT_OFF_CTRL0) begin
        d.rdata[CPT_RUN_BIT] = q.run;
      end else if (ra == CPT_OFF_CTRL1) begin
        d.rdata[7:0] = q.ctrl1;
      end else if (ra == CPT_OFF_CNT_LO) begin
        d.rdata[7:0] = q.count[7:0];
      end else if (ra == CPT_OFF_CNT_HI) begin
        d.rdata[7:0] = q.count[15:8];
      end else if (ra == CPT_OFF_CMPA_LO) begin
        d.rdata[7:0] = q.cmpa[7:0];
      end else if (ra == CPT_OFF_CMPA_HI) begin
        d.rdata[7:0] = q.cmpa[15:8];
      end else if (ra == CPT_OFF_PERIOD) begin
        d.rdata[7:0] = q.period;
      end else if (ra == CPT_OFF_STATUS) begin
        d.rdata[CPT_FLAG_A_BIT] = q.flag_a;
        d.rdata[CPT_FLAG_P_BIT] = q.flag_p;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // one write and one read at a time: readies close while busy
    d.awready = !d.have_aw && !d.bvalid && !do_write;
    d.wready = !d.have_w && !d.bvalid && !do_write;
    d.arready = !d.rvalid;
    // tick prescaler runs only while the timer is on
    if (q.run && !rise) begin
      d.div = tick ? 16'h0 : q.div + 16'h1;
    end else begin
      d.div = 16'h0;
    end
    // counter: zero on run rise, hold while off, else step per tick
    if (rise) begin
      d.count = 16'h0;
      d.pin_level = init_level;
    end else if (q.run && tick) begin
      d.count = clr ? 16'h0 : next_count[15:0];
      if (pwm_mode) begin
        set_a = a_hit;
        set_p = p_hit;
      end else begin
        set_a = a_hit;
        set_p = p_hit && !clear_sel;
        // compare pin only moves on a comparator A match
        if (a_hit) begin
          case (action)
            CPT_ACT_LOW: d.pin_level = 1'b0;
            CPT_ACT_HIGH: d.pin_level = 1'b1;
            CPT_ACT_TOGGLE: d.pin_level = !q.pin_level;
            default: d.pin_level = q.pin_level;
          endcase
        end
      end
    end
    // sticky flags, a match in the clearing cycle wins
    d.flag_a = (q.flag_a && !clr_a) || set_a;
    d.flag_p = (q.flag_p && !clr_p) || set_p;
    // pwm level: counting continues even while the pin is forced
    case (action)
      CPT_PWM_INACTIVE: pwm_level = !init_level;
      CPT_PWM_ACTIVE: pwm_level = init_level;
      CPT_PWM_WAVE: pwm_level = pwm_on ? init_level : !init_level;
      default: pwm_level = !init_level; // single pulse code not built: inactive
    endcase
    // pin drive: released in timer mode and the undefined code
    if (pwm_mode) begin
      d.pin = pwm_level ^ invert;
      d.pin_en_n = 1'b0;
    end else if (mode == CPT_MODE_COMPARE) begin
      d.pin = d.pin_level ^ invert;
      d.pin_en_n = 1'b0;
    end else begin
      d.pin = 1'b0;
      d.pin_en_n = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= CPT_RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign timer_output_pin = q.pin;
  assign timer_output_pin_en_n = q.pin_en_n;

  // helper: a status write that clears flags this cycle, declared ahead of its checker
  logic do_write_w;
  assign do_write_w = q.have_aw && q.have_w && !q.bvalid && q.wstrb0 && ({q.awaddr[7:2], 2'b00} == CPT_OFF_STATUS);

  // run rise zeroes the counter and loads the initial level
  run_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rise |=> (q.count == 16'h0) && (q.pin_level == $past(init_level)))
    else $error("run rise did not reset counter or pin level");

  // counter keeps its residual value while off
  count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.run |=> (q.count == $past(q.count)))
    else $error("counter moved while timer off");

  // one step per tick
  count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.run && !rise && tick && !clr) |=> (q.count == $past(q.count) + 16'h1))
    else $error("counter did not step on tick");

  // comparator P point clears the counter and sets its flag
  p_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.run && !rise && tick && mode == CPT_MODE_COMPARE && !clear_sel && p_hit)
    |=> (q.count == 16'h0) && q.flag_p)
    else $error("comparator P match did not clear counter");

  // no A flag from a zero compare value
  a_zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.cmpa == 16'h0 && !q.flag_a) |=> !q.flag_a)
    else $error("flag A raised with compare A zero");

  // no P flag with clear select high outside pwm
  p_flag_none_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pwm_mode && clear_sel && !q.flag_p) |=> !q.flag_p)
    else $error("flag P raised with clear on A");

  // flag A stays until cleared by software
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.flag_a && !(do_write_w && q.wdata[CPT_FLAG_A_BIT])) |=> q.flag_a)
    else $error("flag A dropped without a clear");

  // timer mode releases the pin
  pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == CPT_MODE_TIMER) |=> q.pin_en_n)
    else $error("pin driven in timer mode");

  // duty at or above period keeps the active level
  pwm_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwm_mode && action == CPT_PWM_WAVE && pwm_duty >= pwm_period && {1'b0, q.count} < pwm_period)
    |=> (q.pin == $past(init_level ^ invert)))
    else $error("pwm not fully active with duty over period");

endmodule : cpt_timer

//--- tb_compare_pwm_timer_16bit.sv
// Purpose: self-checking bench for the compare/pwm timer over its lite register bus
// Assumes: tick_div 1, so one timer tick per aclk; bready and rready held high throughout
// Notes: outputs are sampled on the falling edge, inputs driven after the rising edge
`timescale 1ns/1ps
module tb_compare_pwm_timer_16bit;
  import cpt_pkg::*;
  localparam int LIMIT = 20000; // far above the roughly 6200 cycles the tests need
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic tpin;
  logic tpin_en_n;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  logic [31:0] d;
  logic [1:0] rs;
  // pwm table: control 1, compare A, window, expected active cycles
  // last row: single pulse code, not built here, so the pin sits inactive
  logic [7:0] pc1 [8] = '{8'hA9, 8'hAC, 8'hA0, 8'hAA, 8'hA8, 8'h88, 8'h98, 8'hB8};
  logic [15:0] pa [8] = '{16'h0040, 16'h0040, 16'h0040, 16'h0300, 16'h0100, 16'h0040, 16'h0040, 16'h0040};
  int pw [8] = '{256, 256, 256, 768, 256, 256, 256, 256};
  int ph [8] = '{64, 192, 192, 256, 256, 0, 256, 0};
  // compare mode pin after first A match, init high
  logic pe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  cpt_timer #(.tick_div(16'h0001)) u_cpt_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .timer_output_pin(tpin), .timer_output_pin_en_n(tpin_en_n)
  );

  // free-running 25 MHz clock
  always #20 aclk = ~aclk;

  // hang guard: counts as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic g, input logic e);
    cmp_reg({31'h0, g}, {31'h0, e});
  endtask : cmp_pin

  // one write; both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic sa, sw, sb;
    logic [1:0] r;
    sb = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!sb) begin
      @(negedge aclk);
      sa = awvalid && awready;
      sw = wvalid && wready;
      sb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
    end
    cmp_reg({30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic sa, sr;
    sr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!sr) begin
      @(negedge aclk);
      sa = arvalid && arready;
      sr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (sa) arvalid <= 1'b0;
    end
  endtask : rd

  // read and compare both data and response
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, rs);
    cmp_reg(d, e);
    cmp_reg({30'h0, rs}, {30'h0, er});
  endtask : chk

  // stop, program everything, clear flags, start; the run rise restarts the count
  task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wr(CPT_OFF_CTRL0, 8'h00, CPT_RESP_OKAY);
    wr(CPT_OFF_CTRL1, c1, CPT_RESP_OKAY);
    // high byte first; the timer is stopped, so a passing zero compare A does no harm
    wr(CPT_OFF_CMPA_HI, a[15:8], CPT_RESP_OKAY);
    wr(CPT_OFF_CMPA_LO, a[7:0], CPT_RESP_OKAY);
    wr(CPT_OFF_PERIOD, p, CPT_RESP_OKAY);
    wr(CPT_OFF_STATUS, 8'h03, CPT_RESP_OKAY);
    wr(CPT_OFF_CTRL0, 8'h08, CPT_RESP_OKAY);
  endtask : cfg

  task automatic pin_at(input int n, input logic e);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
    cmp_pin(tpin, e);
    @(posedge aclk);
  endtask : pin_at

  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) chk(8'(4 * i), 32'h00000000, CPT_RESP_OKAY);
    chk(8'h20, 32'h00000000, CPT_RESP_SLVERR);
    wr(8'h20, 8'h55, CPT_RESP_SLVERR);
    wr(CPT_OFF_CNT_LO, 8'hFF, CPT_RESP_OKAY);
    chk(CPT_OFF_CNT_LO, 32'h00000000, CPT_RESP_OKAY);
    wr(CPT_OFF_CMPA_LO, 8'h5A, CPT_RESP_OKAY);
    wr(CPT_OFF_CMPA_HI, 8'hA5, CPT_RESP_OKAY);
    wr(CPT_OFF_PERIOD, 8'h3C, CPT_RESP_OKAY);
    wstrb <= 4'h0;
    wr(CPT_OFF_PERIOD, 8'hFF, CPT_RESP_OKAY);
    wstrb <= 4'hF;
    chk(CPT_OFF_CMPA_LO, 32'h0000005A, CPT_RESP_OKAY);
    chk(CPT_OFF_CMPA_HI, 32'h000000A5, CPT_RESP_OKAY);
    chk(CPT_OFF_PERIOD, 32'h0000003C, CPT_RESP_OKAY);
    // compare mode, clear on P: each pin action after one A match
    for (int i = 0; i < 4; i++) begin
      cfg(8'h08 | 8'(i << 4), 16'h0010, 8'h01);
      pin_at(3, 1'b1);
      cmp_pin(tpin_en_n, 1'b0);
      pin_at(40, pe[i]);
      repeat (300) @(posedge aclk);
      chk(CPT_OFF_STATUS, 32'h00000003, CPT_RESP_OKAY);
      chk(CPT_OFF_CNT_HI, 32'h00000000, CPT_RESP_OKAY);
    end
    // A beyond the P period: no A match, pin untouched by P matches
    cfg(8'h20, 16'h0200, 8'h01);
    pin_at(600, 1'b0);
    chk(CPT_OFF_STATUS, 32'h00000002, CPT_RESP_OKAY);
    // clear on A with P below A: only the A flag
    cfg(8'h09, 16'h0300, 8'h01);
    repeat (800) @(posedge aclk);
    chk(CPT_OFF_STATUS, 32'h00000001, CPT_RESP_OKAY);
    rd(CPT_OFF_CNT_HI, d, rs);
    cmp_reg({31'h0, d < 3}, 32'h00000001);
    // timer mode, A zero: no A clear, no A flag, pin released
    cfg(8'hC1, 16'h0000, 8'h00);
    repeat (300) @(posedge aclk);
    cmp_pin(tpin_en_n, 1'b1);
    chk(CPT_OFF_STATUS, 32'h00000000, CPT_RESP_OKAY);
    chk(CPT_OFF_CNT_HI, 32'h00000001, CPT_RESP_OKAY);
    wr(CPT_OFF_CTRL0, 8'h00, CPT_RESP_OKAY);
    rd(CPT_OFF_CNT_LO, d, rs);
    repeat (20) @(posedge aclk);
    chk(CPT_OFF_CNT_LO, d, CPT_RESP_OKAY);
    chk(CPT_OFF_CNT_HI, 32'h00000001, CPT_RESP_OKAY);
    wr(CPT_OFF_CTRL0, 8'h08, CPT_RESP_OKAY);
    chk(CPT_OFF_CNT_HI, 32'h00000000, CPT_RESP_OKAY);
    // pwm: one full period, count active cycles
    for (int i = 0; i < 8; i++) begin
      cfg(pc1[i], pa[i], 8'h01);
      repeat (8) @(posedge aclk);
      k = 0;
      repeat (pw[i]) begin
        @(negedge aclk);
        if (tpin === 1'b1) k++;
      end
      @(posedge aclk);
      cmp_reg(32'(k), 32'(ph[i]));
      cmp_pin(tpin_en_n, 1'b0);
      if (i != 4) chk(CPT_OFF_STATUS, 32'h00000003, CPT_RESP_OKAY);
    end
    end_sim();
  end
endmodule : tb_compare_pwm_timer_16bit
